// ---- dv/bcg_front_end.sv ----
/*
  Sense front end model: one conversion per go pulse.
  Assumes the gauge enables it; stray_i lets it convert regardless.
*/
module bcg_front_end (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        measure_en_i,
  input  wire logic        go_i,
  input  wire logic        stray_i,
  input  wire logic [10:0] code_i,
  output logic             valid_o,
  output logic      [10:0] data_o
);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      valid_o <= 1'b0;
      data_o  <= 11'h000;
    end else begin
      valid_o <= go_i && (measure_en_i || stray_i);
      data_o  <= go_i ? code_i : ~data_o;
    end
  end
endmodule

// ---- dv/bcg_gauge_properties.sv ----
/*
  Port checker for the battery current gauge.
  Assumes it is bound onto bcg_gauge, one clock, low reset.
*/
module bcg_gauge_props (
  input wire logic        SYS_CLK_I,
  input wire logic        RST_B_I,
  input wire logic        SENSE_VALID_I,
  input wire logic [10:0] SENSE_INPUT_I,
  input wire logic        LOW_POWER_O,
  input wire logic        UNDERVOLTAGE_I,
  input wire logic        LOW_POWER_REQUEST_I,
  input wire logic        READING_BUSY_I,
  input wire logic        NET_WR_I,
  input wire logic [7:0]  NET_WDATA_I,
  input wire logic        CHARGE_WR_I,
  input wire logic [15:0] CURRENT_READING_O,
  input wire logic [7:0]  NET_CAPACITY_O,
  input wire logic [15:0] CHARGE_TOTAL_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);
  ////////////////////////////////////////////////////////////
  a_reading_extend: assert property (
    SENSE_VALID_I && !LOW_POWER_O && !READING_BUSY_I && SENSE_INPUT_I != 11'h400
    |=> CURRENT_READING_O == {{5{$past(SENSE_INPUT_I[10])}}, $past(SENSE_INPUT_I)})
    else $error("reading not sign extended");
  a_read_hold: assert property (
    READING_BUSY_I |=> $stable(CURRENT_READING_O)) else $error("reading moved in read");
  a_lp_freeze: assert property (
    LOW_POWER_O && !NET_WR_I |=> $stable(NET_CAPACITY_O)) else $error("count in low power");
  a_mode_follow: assert property (
    1'b1 |=> LOW_POWER_O == ($past(UNDERVOLTAGE_I) || $past(LOW_POWER_REQUEST_I)))
    else $error("low power mode wrong");
  a_net_write: assert property (
    NET_WR_I |=> NET_CAPACITY_O == $past(NET_WDATA_I)) else $error("net write lost");
  a_net_top: assert property (
    NET_CAPACITY_O == 8'hff && !NET_WR_I |=> NET_CAPACITY_O != 8'h00)
    else $error("net wrapped up");
  a_net_bottom: assert property (
    NET_CAPACITY_O == 8'h00 && !NET_WR_I |=> NET_CAPACITY_O != 8'hff)
    else $error("net wrapped down");
  a_charge_dir: assert property (
    !CHARGE_WR_I && !(SENSE_VALID_I && !LOW_POWER_O && !SENSE_INPUT_I[10])
    |=> $stable(CHARGE_TOTAL_O)) else $error("charge moved without charging");
  c_busy_conv: cover property (READING_BUSY_I && SENSE_VALID_I);
  c_lp_conv: cover property (LOW_POWER_O && SENSE_VALID_I);
  c_net_full: cover property (NET_CAPACITY_O == 8'hff && SENSE_VALID_I);
endmodule

bind bcg_gauge bcg_gauge_props u_props (.SYS_CLK_I, .RST_B_I, .SENSE_VALID_I, .SENSE_INPUT_I,
  .LOW_POWER_O, .UNDERVOLTAGE_I, .LOW_POWER_REQUEST_I, .READING_BUSY_I, .NET_WR_I,
  .NET_WDATA_I, .CHARGE_WR_I, .CURRENT_READING_O, .NET_CAPACITY_O, .CHARGE_TOTAL_O);

// ---- dv/testbench.sv ----
/*
  Self-checking bench for the battery current gauge.
  Assumes a shortened charge-total step and a reference residue model.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TS = 2048;
  logic clk = 0, rst_b = 0, busy = 0, nwr = 0, cwr = 0, dwr = 0, uv = 0, lpr = 0;
  logic go = 0, stray = 0, lp = 0, sv, men, lpo;
  logic [10:0] code = 0, sd;
  logic [7:0] nwd = 0, net, enet = 0;
  logic [15:0] cwd = 0, dwd = 0, rd, chg, dis, erd = 0, echg = 0, edis = 0;
  logic [10:0] cv [7] = '{11'h3ff, 11'h0c8, 11'h014, 11'h7ff, 11'h738, 11'h401, 11'h400};
  int nres = 0, cres = 0, dres = 0, error_cnt = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  bcg_front_end u_fe (.clk_i(clk), .rst_b_i(rst_b), .measure_en_i(men), .go_i(go),
    .stray_i(stray), .code_i(code), .valid_o(sv), .data_o(sd));
  bcg_gauge #(.TOTAL_STEP(TS)) uut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .SENSE_VALID_I(sv),
    .SENSE_INPUT_I(sd), .MEASURE_EN_O(men), .UNDERVOLTAGE_I(uv), .LOW_POWER_REQUEST_I(lpr),
    .LOW_POWER_O(lpo), .READING_BUSY_I(busy), .NET_WR_I(nwr), .NET_WDATA_I(nwd),
    .CHARGE_WR_I(cwr), .CHARGE_WDATA_I(cwd), .DISCHARGE_WR_I(dwr), .DISCHARGE_WDATA_I(dwd),
    .CURRENT_READING_O(rd), .NET_CAPACITY_O(net), .CHARGE_TOTAL_O(chg),
    .DISCHARGE_TOTAL_O(dis));
  ////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_all;
    chk(rd, erd);
    chk({8'h00, net}, {8'h00, enet});
    chk(chg, echg);
    chk(dis, edis);
  endtask
  task conv(input logic [10:0] c);
    int v;
    v = (c == 11'h400) ? -1023 : $signed(c);
    @(posedge clk);
    go <= 1'b1;
    code <= c;
    stray <= lp;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    if (!lp) begin
      if (!busy) erd = 16'(v);
      nres += v;
      if (nres >= 3600) begin
        nres -= 3600;
        if (enet != 8'hff) enet++;
      end else if (nres <= -3600) begin
        nres += 3600;
        if (enet != 8'h00) enet--;
      end
      if (v > 0) cres += v;
      else dres -= v;
      if (cres >= TS) begin
        cres -= TS;
        echg++;
      end
      if (dres >= TS) begin
        dres -= TS;
        edis++;
      end
    end
    @(negedge clk);
    chk_all;
  endtask
  task wr(input int k, input logic [15:0] d);
    @(posedge clk);
    nwd <= d[7:0];
    cwd <= d;
    dwd <= d;
    {nwr, cwr, dwr} <= {k == 0, k == 1, k == 2};
    @(posedge clk);
    {nwr, cwr, dwr} <= 3'b000;
    if (k == 0) enet = d[7:0];
    else if (k == 1) echg = d;
    else edis = d;
    @(negedge clk);
    chk_all;
  endtask
  task mode(input logic u, input logic r);
    @(posedge clk);
    uv <= u;
    lpr <= r;
    lp = u | r;
    @(posedge clk);
    @(negedge clk);
    chk({15'h0, lpo}, {15'h0, lp});
    chk({15'h0, men}, {15'h0, !lp});
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk_all;
    foreach (cv[i]) conv(cv[i]);
    $display("test readings done");
    @(posedge clk) busy <= 1'b1;
    conv(11'h005);
    @(posedge clk) busy <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    erd = 16'h0005;
    chk(rd, erd);
    $display("test read hold done");
    wr(0, 16'h00fe);
    wr(1, 16'hfffe);
    wr(2, 16'h0007);
    repeat (12) conv(11'h3ff);
    wr(0, 16'h00c8);
    wr(0, 16'h0001);
    repeat (12) conv(11'h401);
    $display("test counters done");
    for (int k = 0; k < 2; k++) begin
      mode(k == 0, k == 1);
      conv(11'h123);
      mode(1'b0, 1'b0);
      conv(11'h001);
    end
    $display("test low power done");
    close_out;
  end
  initial begin
    #(25ns * 20000);
    error_cnt++;
    close_out;
  end
endmodule

// ---- src/bcg_defs.svh ----
/*
  Constants of the battery current gauge: widths, reset values, scale
  figures and accumulator step sizes.
  Assumes inclusion by bare name from the gauge design files only.
*/
`ifndef BCG_DEFS_SVH
`define BCG_DEFS_SVH

// raw conversion from the sense front end
`define BCG_SAMPLE_W        11
// stored reading register
`define BCG_READING_W       16
`define BCG_SIGN_EXT_BITS   6
`define BCG_READING_RST     16'h0000
`define BCG_READING_MAX     11'sh3ff
`define BCG_READING_MIN     11'sh401
`define BCG_COUNTS_PER_C    200
// net-capacity counter
`define BCG_NET_W           8
`define BCG_NET_RST         8'h00
`define BCG_NET_MAX         8'hff
`define BCG_NET_MIN         8'h00
`define BCG_NET_FULL        8'hc8
// charge and discharge totals
`define BCG_TOTAL_W         16
`define BCG_TOTAL_RST       16'h0000
// residue arithmetic
`define BCG_RESIDUE_W       19
// conversions per second of the front end
`define BCG_CONV_PER_S      1
// reading-count x conversion units making one net-capacity count (0.005C)
`define BCG_NET_STEP        (3600 * `BCG_CONV_PER_S)
// 0.16C is 32 net-capacity counts
`define BCG_TOTAL_PER_NET   32
`define BCG_TOTAL_STEP      (`BCG_TOTAL_PER_NET * `BCG_NET_STEP)

`endif

// ---- src/bcg_gauge.sv ----
/*
  Battery current gauge: reading register, net-capacity counter and the
  charge and discharge totals of a one-cell battery manager.
  Assumes a sense front end that delivers one signed conversion per
  strobe, and a single-wire host interface that presents register reads
  and writes as plain strobes on the device clock.
*/
`include "bcg_defs.svh"

module bcg_gauge #(
  parameter int unsigned TOTAL_STEP = `BCG_TOTAL_STEP
) (
  input  wire logic                         SYS_CLK_I,
  input  wire logic                         RST_B_I,
  // sense front end
  input  wire logic                         SENSE_VALID_I,
  input  wire logic [`BCG_SAMPLE_W-1:0]     SENSE_INPUT_I,
  output logic                              MEASURE_EN_O,
  // power mode
  input  wire logic                         UNDERVOLTAGE_I,
  input  wire logic                         LOW_POWER_REQUEST_I,
  output logic                              LOW_POWER_O,
  // host access
  input  wire logic                         READING_BUSY_I,
  input  wire logic                         NET_WR_I,
  input  wire logic [`BCG_NET_W-1:0]        NET_WDATA_I,
  input  wire logic                         CHARGE_WR_I,
  input  wire logic [`BCG_TOTAL_W-1:0]      CHARGE_WDATA_I,
  input  wire logic                         DISCHARGE_WR_I,
  input  wire logic [`BCG_TOTAL_W-1:0]      DISCHARGE_WDATA_I,
  output logic [`BCG_READING_W-1:0]         CURRENT_READING_O,
  output logic [`BCG_NET_W-1:0]             NET_CAPACITY_O,
  output logic [`BCG_TOTAL_W-1:0]           CHARGE_TOTAL_O,
  output logic [`BCG_TOTAL_W-1:0]           DISCHARGE_TOTAL_O
);

  bcg_pkg::bcg_mode_type     mode_reg;
  bcg_pkg::bcg_mode_type     mode_next;
  bcg_pkg::bcg_sample_type   sample;
  bcg_pkg::bcg_sample_type   sample_clamped;
  bcg_pkg::bcg_sample_type   charge_amount;
  bcg_pkg::bcg_sample_type   discharge_amount;
  bcg_pkg::bcg_reading_type  reading_wide;
  logic                      conv_done;
  logic [`BCG_READING_W-1:0] current_reading_reg;
  logic [`BCG_READING_W-1:0] pending_reg;
  logic                      pending_valid_reg;
  logic [`BCG_NET_W-1:0]     net_capacity_reg;
  logic [`BCG_TOTAL_W-1:0]   charge_total_reg;
  logic [`BCG_TOTAL_W-1:0]   discharge_total_reg;
  logic                      net_up;
  logic                      net_down;
  logic                      charge_step;
  logic                      discharge_step;

  ////////////////////////////////////////////////////////////////////////
  // power mode

  always_comb begin
    if (UNDERVOLTAGE_I || LOW_POWER_REQUEST_I) begin
      mode_next = bcg_pkg::BCG_MODE_LOW_POWER;
    end else begin
      mode_next = bcg_pkg::BCG_MODE_NORMAL;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mode_reg <= bcg_pkg::BCG_MODE_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_comb begin
    unique case (mode_reg)
      bcg_pkg::BCG_MODE_NORMAL: begin
        MEASURE_EN_O = 1'b1;
        LOW_POWER_O  = 1'b0;
      end
      bcg_pkg::BCG_MODE_LOW_POWER: begin
        MEASURE_EN_O = 1'b0;
        LOW_POWER_O  = 1'b1;
      end
    endcase
  end

  // conversions finishing in low-power mode are dropped
  assign conv_done = SENSE_VALID_I && (mode_reg == bcg_pkg::BCG_MODE_NORMAL);

  ////////////////////////////////////////////////////////////////////////
  // reading format

  assign sample = bcg_pkg::bcg_sample_type'(SENSE_INPUT_I);

  // the most negative raw code has no mirror; pin it to the legal minimum
  always_comb begin
    if (sample < `BCG_READING_MIN) begin
      sample_clamped = `BCG_READING_MIN;
    end else begin
      sample_clamped = sample;
    end
  end

  // top six bits all carry the sign; 200 counts is 1C
  assign reading_wide = bcg_pkg::bcg_reading_type'(sample_clamped);

  ////////////////////////////////////////////////////////////////////////
  // reading register, frozen while the host reads it

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pending_reg       <= `BCG_READING_RST;
      pending_valid_reg <= 1'b0;
    end else if (conv_done && READING_BUSY_I) begin
      pending_reg       <= reading_wide;
      pending_valid_reg <= 1'b1;
    end else if (!READING_BUSY_I) begin
      pending_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      current_reading_reg <= `BCG_READING_RST;
    end else if (!READING_BUSY_I) begin
      if (conv_done) begin
        current_reading_reg <= reading_wide;
      end else if (pending_valid_reg) begin
        current_reading_reg <= pending_reg;
      end
    end
  end

  assign CURRENT_READING_O = current_reading_reg;

  ////////////////////////////////////////////////////////////////////////
  // direction split for the totals

  always_comb begin
    charge_amount    = '0;
    discharge_amount = '0;
    if (sample_clamped > 0) begin
      charge_amount = sample_clamped;
    end else if (sample_clamped < 0) begin
      discharge_amount = -sample_clamped;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sub-step residues

  bcg_residue #(
    .STEP     (`BCG_NET_STEP)
  ) u_net_residue (
    .clk_i    (SYS_CLK_I),
    .rst_b_i  (RST_B_I),
    .add_i    (conv_done),
    .amount_i (sample_clamped),
    .up_o     (net_up),
    .down_o   (net_down)
  );

  bcg_residue #(
    .STEP     (TOTAL_STEP)
  ) u_charge_residue (
    .clk_i    (SYS_CLK_I),
    .rst_b_i  (RST_B_I),
    .add_i    (conv_done),
    .amount_i (charge_amount),
    .up_o     (charge_step),
    .down_o   ()
  );

  bcg_residue #(
    .STEP     (TOTAL_STEP)
  ) u_discharge_residue (
    .clk_i    (SYS_CLK_I),
    .rst_b_i  (RST_B_I),
    .add_i    (conv_done),
    .amount_i (discharge_amount),
    .up_o     (discharge_step),
    .down_o   ()
  );

  ////////////////////////////////////////////////////////////////////////
  // net-capacity counter; a host write in the same cycle wins

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      net_capacity_reg <= `BCG_NET_RST;
    end else if (NET_WR_I) begin
      net_capacity_reg <= NET_WDATA_I;
    end else if (net_up && (net_capacity_reg != `BCG_NET_MAX)) begin
      net_capacity_reg <= net_capacity_reg + 8'h01;
    end else if (net_down && (net_capacity_reg != `BCG_NET_MIN)) begin
      net_capacity_reg <= net_capacity_reg - 8'h01;
    end
  end

  assign NET_CAPACITY_O = net_capacity_reg;

  ////////////////////////////////////////////////////////////////////////
  // charge and discharge totals, up only

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      charge_total_reg <= `BCG_TOTAL_RST;
    end else if (CHARGE_WR_I) begin
      charge_total_reg <= CHARGE_WDATA_I;
    end else if (charge_step) begin
      charge_total_reg <= charge_total_reg + 16'h0001;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      discharge_total_reg <= `BCG_TOTAL_RST;
    end else if (DISCHARGE_WR_I) begin
      discharge_total_reg <= DISCHARGE_WDATA_I;
    end else if (discharge_step) begin
      discharge_total_reg <= discharge_total_reg + 16'h0001;
    end
  end

  assign CHARGE_TOTAL_O    = charge_total_reg;
  assign DISCHARGE_TOTAL_O = discharge_total_reg;

endmodule

// ---- src/bcg_pkg.sv ----
/*
  Types of the battery current gauge.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bcg_pkg;

  typedef enum logic {
    BCG_MODE_NORMAL,
    BCG_MODE_LOW_POWER
  } bcg_mode_type;

  typedef logic signed [10:0] bcg_sample_type;
  typedef logic signed [15:0] bcg_reading_type;

endpackage

// ---- src/bcg_residue.sv ----
/*
  Fractional-step residue for one accumulator: sums signed reading
  contributions and pulses up or down once a whole step has built up.
  Assumes each contribution is smaller in magnitude than one step.
*/
`include "bcg_defs.svh"

module bcg_residue #(
  parameter int unsigned STEP = 3600
) (
  input  wire logic                             clk_i,
  input  wire logic                             rst_b_i,
  input  wire logic                             add_i,
  input  wire logic signed [`BCG_SAMPLE_W-1:0]  amount_i,
  output logic                                  up_o,
  output logic                                  down_o
);

  localparam logic signed [`BCG_RESIDUE_W-1:0] STEP_S = `BCG_RESIDUE_W'(STEP);

  logic signed [`BCG_RESIDUE_W-1:0] residue_reg;
  logic signed [`BCG_RESIDUE_W-1:0] sum;

  assign sum    = residue_reg + `BCG_RESIDUE_W'(amount_i);
  assign up_o   = add_i && (sum >= STEP_S);
  assign down_o = add_i && (sum <= -STEP_S);

  ////////////////////////////////////////////////////////////////////////
  // keep the part below one step for the next reading
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      residue_reg <= '0;
    end else if (add_i) begin
      if (up_o) begin
        residue_reg <= sum - STEP_S;
      end else if (down_o) begin
        residue_reg <= sum + STEP_S;
      end else begin
        residue_reg <= sum;
      end
    end
  end

endmodule
